// file: hdl/tws_defines.svh
/*
  shared constants of the two-wire memory slave front end.
  assumes inclusion by bare name from every design file that needs it.
*/
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

`define TWS_TYPE_NIBBLE   4'h0a
`define TWS_BITS_PER_WORD 4'h8
`define TWS_SYNC_STAGES   2
`define TWS_FIFO_DEPTH    8
`define TWS_WORD_W        8
`define TWS_CLK_HZ        10000000
`define TWS_WR_TIME_MS    5
`define TWS_MS_PER_S      1000
`define TWS_RW_BIT        0
`define TWS_MSB           7

`endif

// file: hdl/tws_pkg.sv
/*
  types of the two-wire memory slave front end.
  assumes nothing beyond a SystemVerilog compiler.
*/
package tws_pkg;

  typedef enum logic [2:0] {
    CAP_1K  = 3'h0,
    CAP_2K  = 3'h1,
    CAP_4K  = 3'h2,
    CAP_8K  = 3'h3,
    CAP_16K = 3'h4
  } tws_cap_e;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_RX    = 7'h04,
    ST_ACK   = 7'h08,
    ST_TX    = 7'h10,
    ST_TXACK = 7'h20,
    ST_WRITE = 7'h40
  } tws_state_e;

endpackage

// file: hdl/tws_stream_if.sv
/*
  valid/ready word stream between the front end and its fifo.
  assumes source and sink share one clock.
*/
`timescale 1ns/1ns
interface tws_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hdl/tws_sync.sv
/*
  two-flop synchroniser for a group of asynchronous levels.
  assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ns
module tws_sync #(
  parameter int W = 5
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // meta_r feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // tws_sync

// file: hdl/tws_fifo.sv
/*
  small fifo with a registered output stage.
  assumes the sink may stall at will; in.ready falls when storage is full.
*/
`timescale 1ns/1ns
module tws_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  tws_stream_if.snk in_s,
  tws_stream_if.src out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [W-1:0]  out_data_r;
  logic          out_valid_r;
  logic          push;
  logic          pop;

  assign in_s.ready  = (count_r != CW'(DEPTH));
  assign push        = in_s.valid && in_s.ready;
  assign pop         = (count_r != '0) && (!out_valid_r || out_s.ready);
  assign out_s.valid = out_valid_r;
  assign out_s.data  = out_data_r;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_s.data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop) rd_ptr_r <= ptr_inc(rd_ptr_r);
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end

  // read data leaves through a register so the sink sees no memory path
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (pop) begin
      out_valid_r <= 1'b1;
      out_data_r  <= mem_r[rd_ptr_r];
    end else if (out_s.ready) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule // tws_fifo

// file: hdl/tws_slave.sv
/*
  two-wire memory slave front end: start/stop detection, word shifting with
  ninth-clock acknowledge, device address compare, page bits, standby and
  the self-timed write window. assumes scl/sda and select pins are async
  and the outside resolves the open-drain wire from sda_oe_n.
*/
// Behaviour
// - data may change only while clock low
// - sda fall with scl high: start, except during internal write
// - sda rise with scl high: stop, ends transaction
// - stop after read enters standby
// - words move as eight bits, one per clock
// - drive acknowledge low on ninth clock
// - standby at power-up and after stop; code waits for the write window to end after a write
// - internal write finishes within five milliseconds
// - top nibble must match fixed type pattern
// - small capacities compare three select pins
// - 4K compares two pins, one page bit
// - 8K compares one pin, two page bits
// - 16K compares none, three page bits
// - page bits become word address high bits
// - eighth address bit high reads, low writes
// - match acknowledges; mismatch returns to standby
// - ignore bus during internal write
// - polling acknowledged only after write finishes
`timescale 1ns/1ns
`include "tws_defines.svh"
module tws_slave #(
  parameter tws_pkg::tws_cap_e CAPACITY   = tws_pkg::CAP_2K,
  parameter int                WR_CYCLES  = `TWS_WR_TIME_MS * (`TWS_CLK_HZ / `TWS_MS_PER_S),
  parameter int                FIFO_DEPTH = `TWS_FIFO_DEPTH
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       chip_select_pin_high,
  input  wire logic       chip_select_pin_mid,
  input  wire logic       chip_select_pin_low,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_byte,
  output logic            tx_load,
  output logic            read_op,
  output logic [2:0]      page_bits,
  output logic            standby,
  output logic            write_busy,
  output logic            start_seen,
  output logic            stop_seen
);
  localparam int WR_W = $clog2(WR_CYCLES + 1);

  tws_pkg::tws_state_e state_r;
  logic [4:0]          sync_q;
  logic                scl_s;
  logic                sda_s;
  logic [2:0]          pins_s;
  logic                scl_d_r;
  logic                sda_d_r;
  logic [3:0]          bit_cnt_r;
  logic [7:0]          shift_r;
  logic [7:0]          tx_shift_r;
  logic                is_addr_r;
  logic                wrote_r;
  logic                mack_r;
  logic [WR_W-1:0]     wr_cnt_r;
  logic                sda_oe_n_r;
  logic                sda_out_r;
  logic                rw_r;
  logic [2:0]          page_r;
  logic                standby_r;
  logic                busy_r;
  logic                tx_load_r;
  logic                start_r;
  logic                stop_r;
  logic                push_r;
  logic [7:0]          push_data_r;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_evt;
  logic                stop_evt;
  logic                byte_done;
  logic                match;
  logic                wr_done;

  tws_stream_if #(.W(`TWS_WORD_W)) fin_if ();
  tws_stream_if #(.W(`TWS_WORD_W)) fout_if ();

  tws_sync #(.W(5)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        ({scl, sda_in, chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low}),
    .q        (sync_q)
  );

  assign scl_s  = sync_q[4];
  assign sda_s  = sync_q[3];
  assign pins_s = sync_q[2:0];

  tws_fifo #(.W(`TWS_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk (core_clk),
    .nrst     (nrst),
    .in_s     (fin_if.snk),
    .out_s    (fout_if.src)
  );

  assign fin_if.valid  = push_r;
  assign fin_if.data   = push_data_r;
  assign fout_if.ready = rx_ready;
  assign rx_valid      = fout_if.valid;
  assign rx_data       = fout_if.data;

  // address compare per capacity; unused select pins are ignored
  function automatic logic addr_match(input logic [7:0] w, input logic [2:0] p);
    logic ok;
    ok = (w[7:4] == `TWS_TYPE_NIBBLE);
    case (CAPACITY)
      tws_pkg::CAP_4K:  ok = ok && (w[3:2] == p[2:1]);
      tws_pkg::CAP_8K:  ok = ok && (w[3] == p[2]);
      tws_pkg::CAP_16K: ok = ok;
      default:          ok = ok && (w[3:1] == p);
    endcase
    return ok;
  endfunction

  // select positions not compared carry high word-address bits
  function automatic logic [2:0] page_of(input logic [7:0] w);
    logic [2:0] pg;
    case (CAPACITY)
      tws_pkg::CAP_4K:  pg = {2'h0, w[1]};
      tws_pkg::CAP_8K:  pg = {1'h0, w[2:1]};
      tws_pkg::CAP_16K: pg = w[3:1];
      default:          pg = 3'h0;
    endcase
    return pg;
  endfunction

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // sda moving while scl stays high is framing, never data
  assign scl_rise  = scl_s && !scl_d_r;
  assign scl_fall  = !scl_s && scl_d_r;
  assign start_evt = !busy_r && scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_evt  = !busy_r && scl_s && scl_d_r && !sda_d_r && sda_s;
  assign byte_done = (bit_cnt_r == `TWS_BITS_PER_WORD);
  assign match     = addr_match(shift_r, pins_s);
  assign wr_done   = busy_r && (wr_cnt_r == WR_W'(WR_CYCLES - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= tws_pkg::ST_IDLE;
    end else if (start_evt) begin
      state_r <= tws_pkg::ST_ADDR;
    end else if (stop_evt) begin
      state_r <= wrote_r ? tws_pkg::ST_WRITE : tws_pkg::ST_IDLE;
    end else begin
      case (state_r)
        tws_pkg::ST_ADDR: begin
          if (scl_fall && byte_done) begin
            state_r <= match ? tws_pkg::ST_ACK : tws_pkg::ST_IDLE;
          end
        end
        tws_pkg::ST_RX: begin
          // a full fifo refuses the word by withholding acknowledge
          if (scl_fall && byte_done) begin
            state_r <= fin_if.ready ? tws_pkg::ST_ACK : tws_pkg::ST_IDLE;
          end
        end
        tws_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_r <= (is_addr_r && rw_r) ? tws_pkg::ST_TX : tws_pkg::ST_RX;
          end
        end
        tws_pkg::ST_TX: begin
          if (scl_fall && byte_done) state_r <= tws_pkg::ST_TXACK;
        end
        tws_pkg::ST_TXACK: begin
          if (scl_fall) state_r <= mack_r ? tws_pkg::ST_TX : tws_pkg::ST_IDLE;
        end
        tws_pkg::ST_WRITE: begin
          if (wr_done) state_r <= tws_pkg::ST_IDLE;
        end
        default: state_r <= tws_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
    end else if (start_evt) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && (state_r == tws_pkg::ST_ADDR || state_r == tws_pkg::ST_RX)) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= {shift_r[6:0], sda_s};
    end else if (scl_rise && state_r == tws_pkg::ST_TX) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (scl_fall && (state_r == tws_pkg::ST_ACK || state_r == tws_pkg::ST_TXACK)) begin
      bit_cnt_r <= 4'h0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      is_addr_r <= 1'b0;
      rw_r      <= 1'b0;
      page_r    <= 3'h0;
    end else if (start_evt) begin
      is_addr_r <= 1'b1;
    end else if (scl_fall && byte_done && state_r == tws_pkg::ST_ADDR) begin
      rw_r   <= shift_r[`TWS_RW_BIT];
      page_r <= page_of(shift_r);
    end else if (scl_fall && state_r == tws_pkg::ST_ACK) begin
      is_addr_r <= 1'b0;
    end
  end

  // a word address alone with a stop also arms the write window
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrote_r <= 1'b0;
    end else if (start_evt || stop_evt) begin
      wrote_r <= 1'b0;
    end else if (scl_fall && byte_done && state_r == tws_pkg::ST_RX && fin_if.ready) begin
      wrote_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      push_r      <= 1'b0;
      push_data_r <= 8'h00;
    end else begin
      push_r <= scl_fall && byte_done && state_r == tws_pkg::ST_RX && fin_if.ready;
      if (scl_fall && byte_done && state_r == tws_pkg::ST_RX) push_data_r <= shift_r;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mack_r <= 1'b0;
    end else if (scl_rise && state_r == tws_pkg::ST_TXACK) begin
      mack_r <= !sda_s;
    end
  end

  // outgoing bits change on scl fall only, so they never look like framing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_shift_r <= 8'h00;
      tx_load_r  <= 1'b0;
    end else begin
      tx_load_r <= 1'b0;
      if (scl_fall && ((state_r == tws_pkg::ST_ACK && is_addr_r && rw_r) ||
                       (state_r == tws_pkg::ST_TXACK && mack_r))) begin
        tx_shift_r <= tx_byte;
        tx_load_r  <= 1'b1;
      end else if (scl_fall && state_r == tws_pkg::ST_TX) begin
        tx_shift_r <= {tx_shift_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sda_oe_n_r <= 1'b1;
    end else if (start_evt || stop_evt || busy_r) begin
      sda_oe_n_r <= 1'b1;
    end else if (scl_fall) begin
      case (state_r)
        tws_pkg::ST_ADDR:  if (byte_done) sda_oe_n_r <= !match;
        tws_pkg::ST_RX:    if (byte_done) sda_oe_n_r <= !fin_if.ready;
        tws_pkg::ST_ACK:   sda_oe_n_r <= (is_addr_r && rw_r) ? tx_byte[`TWS_MSB] : 1'b1;
        tws_pkg::ST_TX:    sda_oe_n_r <= byte_done ? 1'b1 : tx_shift_r[6];
        tws_pkg::ST_TXACK: sda_oe_n_r <= mack_r ? tx_byte[`TWS_MSB] : 1'b1;
        default:           sda_oe_n_r <= 1'b1;
      endcase
    end
  end

  // the pad value is fixed low; only the enable moves
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_r   <= 1'b0;
      wr_cnt_r <= '0;
    end else if (stop_evt && wrote_r) begin
      busy_r   <= 1'b1;
      wr_cnt_r <= '0;
    end else if (wr_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      wr_cnt_r <= wr_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      standby_r <= 1'b1;
    end else if (start_evt) begin
      standby_r <= 1'b0;
    end else if ((stop_evt && !wrote_r) || wr_done) begin
      standby_r <= 1'b1;
    end else if (scl_fall && byte_done && state_r == tws_pkg::ST_ADDR && !match) begin
      standby_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
    end else begin
      start_r <= start_evt;
      stop_r  <= stop_evt;
    end
  end

  assign sda_out    = sda_out_r;
  assign sda_oe_n   = sda_oe_n_r;
  assign tx_load    = tx_load_r;
  assign read_op    = rw_r;
  assign page_bits  = page_r;
  assign standby    = standby_r;
  assign write_busy = busy_r;
  assign start_seen = start_r;
  assign stop_seen  = stop_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_drive_only_ack_tx;
    !sda_oe_n_r |-> (state_r == tws_pkg::ST_ACK || state_r == tws_pkg::ST_TX);
  endproperty
  a_drive_only_ack_tx: assert property (p_drive_only_ack_tx) else $error("sda driven outside ack or tx");

  property p_start_addr;
    start_evt |=> state_r == tws_pkg::ST_ADDR && bit_cnt_r == 4'h0 && start_r;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_stop_end;
    stop_evt |=> (state_r == tws_pkg::ST_IDLE || state_r == tws_pkg::ST_WRITE) && sda_oe_n_r;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop did not end transaction");

  property p_read_stop_standby;
    stop_evt && !wrote_r |=> standby_r && !busy_r;
  endproperty
  a_read_stop_standby: assert property (p_read_stop_standby) else $error("no standby after stop");

  property p_ack_ninth;
    scl_fall && byte_done && state_r == tws_pkg::ST_ADDR && match && !start_evt && !stop_evt
      |=> !sda_oe_n_r && state_r == tws_pkg::ST_ACK;
  endproperty
  a_ack_ninth: assert property (p_ack_ninth) else $error("no acknowledge on ninth clock");

  property p_nomatch;
    scl_fall && byte_done && state_r == tws_pkg::ST_ADDR && !match && !start_evt && !stop_evt
      |=> sda_oe_n_r && standby_r && state_r == tws_pkg::ST_IDLE;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("mismatch not refused");

  property p_write_len;
    busy_r && wr_cnt_r == WR_W'(WR_CYCLES - 1) |=> !busy_r && standby_r;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write window wrong length");

  property p_busy_silent;
    busy_r |-> sda_oe_n_r && !start_evt && state_r == tws_pkg::ST_WRITE;
  endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("bus answered during write");

  property p_bit_step;
    scl_rise && state_r == tws_pkg::ST_ADDR && !start_evt |=> bit_cnt_r == $past(bit_cnt_r) + 4'h1;
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("bit count did not step");

  property p_rw_capture;
    scl_fall && byte_done && state_r == tws_pkg::ST_ADDR && !start_evt && !stop_evt
      |=> rw_r == $past(shift_r[0]);
  endproperty
  a_rw_capture: assert property (p_rw_capture) else $error("rw bit not captured");
endmodule // tws_slave

// file: test/tws_ctrl_model.sv
/*
  bus controller model: drives scl and pulls or releases sda.
  assumes a pull-up on sda and a 10 MHz core_clk to pace an 800 ns bit.
*/
`timescale 1ns/1ns
module tws_ctrl_model (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  initial begin
    scl     = 1'h1;
    sda_rel = 1'h1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // sda is released before scl rises, so the same task also makes a repeated start
  task automatic start_cond();
    sda_rel = 1'h1;
    cyc(2);
    scl = 1'h1;
    cyc(4);
    sda_rel = 1'h0;
    cyc(4);
    scl = 1'h0;
    cyc(2);
  endtask

  task automatic stop_cond();
    sda_rel = 1'h0;
    cyc(2);
    scl = 1'h1;
    cyc(4);
    sda_rel = 1'h1;
    cyc(8);
  endtask

  // four clocks low, four high; the line is read mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    cyc(2);
    scl = 1'h1;
    cyc(2);
    r = sda_line;
    cyc(2);
    scl = 1'h0;
    cyc(2);
  endtask

  // a released bit reads what the device drives, so one task serves both ways
  task automatic word_io(input logic [7:0] w, input logic ack_o, output logic [7:0] rd, output logic ack_i);
    for (int i = 7; i >= 0; i--) bit_io(w[i], rd[i]);
    bit_io(ack_o, ack_i);
  endtask

  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) begin
      bit_io(1'h1, r);
      if (r) break;
    end
    start_cond();
  endtask
endmodule  // tws_ctrl_model

// file: test/test_two_wire_eeprom_slave_front_end.sv
/*
  self-checking bench: a 2K and an 8K front end share one bus with a controller model.
  assumes the design's own assertions guard the cycle-level pin timing.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module test_two_wire_eeprom_slave_front_end;
  logic       core_clk, nrst, rx_ready, scl, sda_rel;
  logic [7:0] tx_b, a_rx_data;
  logic [2:0] pins_a, pins_b, a_page, b_page;
  logic       a_out, a_oe_n, a_rx_valid, a_tx_load, a_read_op, a_standby, a_busy, a_start, a_stop;
  logic       b_out, b_oe_n, b_tx_load, b_read_op, b_standby, b_busy, b_start, b_stop;
  wire        sda_line;
  int         n_errors, checks_done, n_a_start, n_a_stop, n_b_start, n_b_stop;

  // wired-and with pull-up: a released line reads high
  assign sda_line = sda_rel & (a_oe_n | a_out) & (b_oe_n | b_out);

  // framing pulses last one cycle, so counting them catches a lost or extra one
  always @(posedge core_clk) begin
    if (a_start) n_a_start++;
    if (a_stop) n_a_stop++;
    if (b_start) n_b_start++;
    if (b_stop) n_b_stop++;
  end

  tws_ctrl_model i_tws_ctrl_model (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

  tws_slave #(.CAPACITY(tws_pkg::CAP_2K), .WR_CYCLES(200)) i_tws_slave (
    .core_clk(core_clk), .nrst(nrst), .scl(scl), .sda_in(sda_line), .sda_out(a_out), .sda_oe_n(a_oe_n),
    .chip_select_pin_high(pins_a[2]), .chip_select_pin_mid(pins_a[1]), .chip_select_pin_low(pins_a[0]),
    .rx_data(a_rx_data), .rx_valid(a_rx_valid), .rx_ready(rx_ready), .tx_byte(tx_b), .tx_load(a_tx_load),
    .read_op(a_read_op), .page_bits(a_page), .standby(a_standby), .write_busy(a_busy), .start_seen(a_start),
    .stop_seen(a_stop));

  tws_slave #(.CAPACITY(tws_pkg::CAP_8K), .WR_CYCLES(200)) i_tws_slave_8k (
    .core_clk(core_clk), .nrst(nrst), .scl(scl), .sda_in(sda_line), .sda_out(b_out), .sda_oe_n(b_oe_n),
    .chip_select_pin_high(pins_b[2]), .chip_select_pin_mid(pins_b[1]), .chip_select_pin_low(pins_b[0]),
    .rx_data(), .rx_valid(), .rx_ready(rx_ready), .tx_byte(tx_b), .tx_load(b_tx_load),
    .read_op(b_read_op), .page_bits(b_page), .standby(b_standby), .write_busy(b_busy), .start_seen(b_start),
    .stop_seen(b_stop));

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  // next read byte is the inverse, so a missed load shows as a repeat
  initial begin
    tx_b = 8'h3c;
    forever begin
      @(posedge core_clk);
      #1;
      if (a_tx_load | b_tx_load) tx_b = ~tx_b;
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int k = 0; k < n && s !== v; k++) i_tws_ctrl_model.cyc(1);
    if (s !== v) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  endtask

  task automatic t_reset();
    `CHK(a_standby, 1'h1)
    `CHK(b_standby, 1'h1)
    `CHK(a_oe_n, 1'h1)
    `CHK(a_busy, 1'h0)
  endtask

  // sink stalls: nine words fit, the tenth is refused, then drained in order
  task automatic t_fill();
    logic [7:0] rd;
    logic       ak;
    rx_ready = 1'h0;
    i_tws_ctrl_model.start_cond();
    `CHK(a_standby, 1'h0)
    i_tws_ctrl_model.word_io(8'haa, 1'h1, rd, ak);
    `CHK(ak, 1'h0)
    `CHK(a_read_op, 1'h0)
    `CHK(a_page, 3'h0)
    for (int i = 0; i < 10; i++) begin
      i_tws_ctrl_model.word_io(8'h30 + i[7:0], 1'h1, rd, ak);
      `CHK(ak, (i == 9))
    end
    i_tws_ctrl_model.stop_cond();
    for (int i = 0; i < 9; i++) begin
      wait_for(a_rx_valid, 1'h1, 20);
      `CHK(a_rx_data, 8'h30 + i[7:0])
      rx_ready = 1'h1;
      i_tws_ctrl_model.cyc(1);
      rx_ready = 1'h0;
      i_tws_ctrl_model.cyc(1);
    end
    i_tws_ctrl_model.cyc(3);
    `CHK(a_rx_valid, 1'h0)
    rx_ready = 1'h1;
    wait_for(a_standby, 1'h1, 400);
  endtask

  task automatic t_write_poll();
    logic [7:0] rd;
    logic       ak;
    int         a0, a1, b0, b1;
    i_tws_ctrl_model.start_cond();
    i_tws_ctrl_model.word_io(8'haa, 1'h1, rd, ak);
    i_tws_ctrl_model.word_io(8'h5a, 1'h1, rd, ak);
    `CHK(ak, 1'h0)
    i_tws_ctrl_model.stop_cond();
    `CHK(a_busy, 1'h1)
    `CHK(a_standby, 1'h0)
    a0 = n_a_start;
    a1 = n_a_stop;
    b0 = n_b_start;
    b1 = n_b_stop;
    i_tws_ctrl_model.start_cond();
    i_tws_ctrl_model.word_io(8'haa, 1'h1, rd, ak);
    `CHK(ak, 1'h1)
    i_tws_ctrl_model.stop_cond();
    `CHK(n_a_start, a0)
    `CHK(n_a_stop, a1)
    `CHK(n_b_start, b0 + 1)
    `CHK(n_b_stop, b1 + 1)
    wait_for(a_standby, 1'h1, 300);
    `CHK(a_busy, 1'h0)
    i_tws_ctrl_model.start_cond();
    i_tws_ctrl_model.word_io(8'haa, 1'h1, rd, ak);
    `CHK(ak, 1'h0)
    i_tws_ctrl_model.stop_cond();
    `CHK(a_busy, 1'h0)
    `CHK(n_a_start, a0 + 1)
    `CHK(n_a_stop, a1 + 1)
  endtask

  task automatic t_mismatch();
    logic [7:0] rd;
    logic       ak;
    logic [7:0] bad [3] = '{8'hba, 8'h2a, 8'hae};
    for (int i = 0; i < 3; i++) begin
      i_tws_ctrl_model.start_cond();
      i_tws_ctrl_model.word_io(bad[i], 1'h1, rd, ak);
      `CHK(ak, 1'h1)
      i_tws_ctrl_model.cyc(4);
      `CHK(a_standby, 1'h1)
    end
    i_tws_ctrl_model.stop_cond();
    pins_a = 3'h7;
    i_tws_ctrl_model.start_cond();
    i_tws_ctrl_model.word_io(8'hae, 1'h1, rd, ak);
    `CHK(ak, 1'h0)
    i_tws_ctrl_model.stop_cond();
    // only the top select pin counts for the 8K part, so its low pins may differ
    pins_a = 3'h5;
    pins_b = 3'h4;
    i_tws_ctrl_model.start_cond();
    i_tws_ctrl_model.word_io(8'hac, 1'h1, rd, ak);
    `CHK(ak, 1'h0)
    `CHK(b_page, 3'h2)
    `CHK(a_standby, 1'h1)
    i_tws_ctrl_model.stop_cond();
    pins_b = 3'h3;
  endtask

  // random read through a repeated start, two bytes, the last one refused
  task automatic t_read_8k();
    logic [7:0] rd;
    logic       ak;
    i_tws_ctrl_model.start_cond();
    i_tws_ctrl_model.word_io(8'ha6, 1'h1, rd, ak);
    `CHK(ak, 1'h0)
    `CHK(a_standby, 1'h1)
    i_tws_ctrl_model.word_io(8'h40, 1'h1, rd, ak);
    i_tws_ctrl_model.start_cond();
    i_tws_ctrl_model.word_io(8'ha7, 1'h1, rd, ak);
    `CHK(ak, 1'h0)
    `CHK(b_read_op, 1'h1)
    `CHK(b_page, 3'h3)
    i_tws_ctrl_model.word_io(8'hff, 1'h0, rd, ak);
    `CHK(rd, 8'h3c)
    i_tws_ctrl_model.word_io(8'hff, 1'h1, rd, ak);
    `CHK(rd, 8'hc3)
    i_tws_ctrl_model.stop_cond();
    `CHK(b_standby, 1'h1)
    `CHK(b_busy, 1'h0)
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    n_errors    = 0;
    checks_done = 0;
    nrst        = 1'h0;
    rx_ready    = 1'h1;
    pins_a      = 3'h5;
    pins_b      = 3'h3;
    repeat (12) @(posedge core_clk);
    #1;
    nrst = 1'h1;
    i_tws_ctrl_model.cyc(4);
    t_reset();
    i_tws_ctrl_model.recover();
    i_tws_ctrl_model.stop_cond();
    t_fill();
    t_write_poll();
    t_mismatch();
    t_read_8k();
    tally_and_finish();
  end
endmodule  // test_two_wire_eeprom_slave_front_end
